// *** rtl/cdt_params.svh ***
// offsets, field masks, reset values and timing figures of the timer 3 / wake-up block
// assumes the includer imports cdt_pkg for the types
`ifndef CDT_PARAMS_SVH
`define CDT_PARAMS_SVH
// register indices; byte address is four times the index
`define CDT_IDX_T3_CTRL 8'h1e
`define CDT_IDX_RELOAD_HI 8'h1f
`define CDT_IDX_RELOAD_LO 8'h20
`define CDT_IDX_COUNT_HI 8'h21
`define CDT_IDX_COUNT_LO 8'h22
`define CDT_IDX_WK_CTRL 8'h23
`define CDT_IDX_IRQ_STATUS 8'h30
`define CDT_IDX_IRQ_CLEAR 8'h31
`define CDT_IDX_IRQ_ENABLE 8'h32
// field layout
`define CDT_T3_CTRL_WMASK 8'hbb
`define CDT_T3_CTRL_RSV_MASK 8'h44
`define CDT_WK_RUN_BIT 7
`define CDT_WK_STROBE_BIT 6
`define CDT_IRQ_T3_BIT 0
`define CDT_IRQ_WK_BIT 1
// reset values
`define CDT_RST_BYTE 8'h00
`define CDT_RST_COUNT 16'h0000
`define CDT_RST_IRQ 2'h0
// timing: 13.56 MHz made from the 40 MHz bus clock by a fractional accumulator
`define CDT_CLK_KHZ 16'd40000
`define CDT_SYS_KHZ 16'd13560
// subcarrier 211.875 kHz is the 13.56 MHz rate divided by 64
`define CDT_SUBC_LAST 6'h3f
`endif

// *** rtl/cdt_pkg.sv ***
// types shared by the timer 3 / wake-up control block
// assumes nothing beyond a SystemVerilog compiler
package cdt_pkg;
  typedef struct packed {
    logic stop_on_receive;
    logic rsv6;
    logic [1:0] start_mode_sel;
    logic auto_reload_en;
    logic rsv2;
    logic [1:0] count_clock_sel;
  } cdt_t3_ctrl_t;
  typedef struct packed {
    logic wakeup_auto_trim;
    logic wakeup_auto_card_detect;
    logic wakeup_auto_reload;
    logic wakeup_auto_wake;
    logic [1:0] wakeup_clock_sel;
  } cdt_wk_cfg_t;
  typedef struct packed {
    logic tx_end;
    logic rx_nibble_done;
    logic timer0_underflow;
    logic timer1_underflow;
    logic wakeup_expire;
  } cdt_events_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } cdt_bus_req_t;
  typedef enum logic [1:0] {CDT_IDLE = 2'b01, CDT_RUN = 2'b10} cdt_state_t;
  typedef enum logic [1:0] {
    CDT_START_NONE = 2'b00,
    CDT_START_TX = 2'b01,
    CDT_TRIM_HOLD = 2'b10,
    CDT_TRIM_WRAP = 2'b11
  } cdt_start_t;
  typedef enum logic [1:0] {
    CDT_CLK_SYS = 2'b00,
    CDT_CLK_SUBC = 2'b01,
    CDT_CLK_T0 = 2'b10,
    CDT_CLK_T1 = 2'b11
  } cdt_clk_t;
endpackage

// *** rtl/cdt_timer3_wakeup.sv ***
// timer 3 countdown counter, wake-up timer control bits, AHB-Lite register slave
// assumes chip_events are one-cycle pulses on hclk; lfo_clock_pin is asynchronous
// What this block does
// - with stop_on_receive set, a running countdown halts once the first 4 rx bits arrive.
// - stop_on_receive has no effect while a trimming start mode is selected.
// - start_mode_sel picks none, start at tx end, trim without or with underflow.
// - with auto_reload_en set, an underflow reloads the counter and counting goes on.
// - with auto_reload_en clear, the counter stops at zero until the next start.
// - every underflow sets the sticky underflow_irq_flag.
// - count_clock_sel 00 counts 13.56 MHz ticks, 01 counts 211.875 kHz ticks.
// - count_clock_sel 10 and 11 count underflows of timer 0 and timer 1.
// - each start event loads the counter with reload_value from the two reload bytes.
// - reload writes never touch a running count; they apply at the next start or auto-reload underflow.
// - the live counter is readable as count_high_byte and count_low_byte.
// - wake-up expiry can wake the system and launch card detection when enabled.
// - wakeup_running changes by write only when wakeup_run_change_strobe is also set.
// - wakeup_clock_sel picks the low_freq_oscillator divided by 1, 8, 16 or 32.
`include "cdt_params.svh"
module cdt_timer3_wakeup (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire cdt_pkg::cdt_events_t chip_events,
  input wire logic lfo_clock_pin,
  output logic irq,
  output logic timer3_underflow,
  output logic wake_request,
  output logic card_detect_start,
  output logic trim_request,
  output logic wakeup_tick,
  output logic wakeup_running
);
  import cdt_pkg::*;

  function automatic logic cdt_hit(input logic [31:0] a, input logic [7:0] idx);
    cdt_hit = (a == {22'h0, idx, 2'b00});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic hreadyout_ff, hresp_ff;
  logic [31:0] hrdata_ff, nxt_hrdata;
  cdt_bus_req_t req_ff, nxt_req;
  cdt_t3_ctrl_t t3_ctrl_ff;
  logic [7:0] reload_hi_ff, reload_lo_ff;
  logic [15:0] count_ff, nxt_count;
  cdt_state_t state_ff, nxt_state;
  cdt_wk_cfg_t wk_cfg_ff;
  logic wk_run_ff, nxt_wk_run;
  logic [1:0] irq_status_ff, irq_en_ff, nxt_status;
  logic irq_ff, t3_uf_ff, wake_req_ff, card_det_ff, trim_req_ff, wk_tick_ff;
  logic [15:0] sys_acc_ff, nxt_sys_acc;
  logic sys_tick_ff;
  logic [5:0] subc_div_ff;
  logic lfo_meta_ff, lfo_sync_ff, lfo_prev_ff;
  logic [4:0] lfo_div_ff;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; zero wait states, every access answers OKAY
  wire addr_phase = hsel & hready & htrans[1];
  assign nxt_req = '{valid: addr_phase, write: hwrite, addr: haddr};
  wire wr_cycle = req_ff.valid & req_ff.write;
  wire wr_t3_ctrl = wr_cycle & cdt_hit(req_ff.addr, `CDT_IDX_T3_CTRL);
  wire wr_reload_hi = wr_cycle & cdt_hit(req_ff.addr, `CDT_IDX_RELOAD_HI);
  wire wr_reload_lo = wr_cycle & cdt_hit(req_ff.addr, `CDT_IDX_RELOAD_LO);
  wire wr_wk_ctrl = wr_cycle & cdt_hit(req_ff.addr, `CDT_IDX_WK_CTRL);
  wire wr_irq_clear = wr_cycle & cdt_hit(req_ff.addr, `CDT_IDX_IRQ_CLEAR);
  wire wr_irq_enable = wr_cycle & cdt_hit(req_ff.addr, `CDT_IDX_IRQ_ENABLE);
  wire [7:0] wbyte = hwdata[7:0];
  wire rd_phase = addr_phase & ~hwrite;

  wire [15:0] reload_value = {reload_hi_ff, reload_lo_ff};
  wire [7:0] wk_ctrl_rd = {wk_run_ff, 1'b0, wk_cfg_ff};
  // counter bytes are taken live at the address phase; a 16-bit pair read is not atomic
  wire [7:0] rd_byte =
    cdt_hit(haddr, `CDT_IDX_T3_CTRL) ? t3_ctrl_ff :
    cdt_hit(haddr, `CDT_IDX_RELOAD_HI) ? reload_hi_ff :
    cdt_hit(haddr, `CDT_IDX_RELOAD_LO) ? reload_lo_ff :
    cdt_hit(haddr, `CDT_IDX_COUNT_HI) ? count_ff[15:8] :
    cdt_hit(haddr, `CDT_IDX_COUNT_LO) ? count_ff[7:0] :
    cdt_hit(haddr, `CDT_IDX_WK_CTRL) ? wk_ctrl_rd :
    cdt_hit(haddr, `CDT_IDX_IRQ_STATUS) ? {6'h00, irq_status_ff} :
    cdt_hit(haddr, `CDT_IDX_IRQ_ENABLE) ? {6'h00, irq_en_ff} : 8'h00;
  assign nxt_hrdata = rd_phase ? {24'h000000, rd_byte} : hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_ff <= '0;
      hrdata_ff <= 32'h00000000;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      req_ff <= nxt_req;
      hrdata_ff <= nxt_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      t3_ctrl_ff <= `CDT_RST_BYTE;
      reload_hi_ff <= `CDT_RST_BYTE;
      reload_lo_ff <= `CDT_RST_BYTE;
      wk_cfg_ff <= '0;
      irq_en_ff <= `CDT_RST_IRQ;
    end else begin
      if (wr_t3_ctrl) t3_ctrl_ff <= wbyte & `CDT_T3_CTRL_WMASK;
      if (wr_reload_hi) reload_hi_ff <= wbyte;
      if (wr_reload_lo) reload_lo_ff <= wbyte;
      if (wr_wk_ctrl) wk_cfg_ff <= wbyte[5:0];
      if (wr_irq_enable) irq_en_ff <= wbyte[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick sources: 13.56 MHz by accumulator, subcarrier by 64, lfo edges synchronised
  // 40 MHz cannot be divided evenly to 13.56 MHz, so ticks land 2 or 3 cycles apart
  wire [15:0] sys_sum = sys_acc_ff + `CDT_SYS_KHZ;
  wire sys_wrap = sys_sum >= `CDT_CLK_KHZ;
  assign nxt_sys_acc = sys_wrap ? sys_sum - `CDT_CLK_KHZ : sys_sum;
  wire subc_tick = sys_tick_ff & (subc_div_ff == `CDT_SUBC_LAST);
  wire lfo_rise = lfo_sync_ff & ~lfo_prev_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_acc_ff <= 16'h0000;
      sys_tick_ff <= 1'b0;
      subc_div_ff <= 6'h00;
      lfo_meta_ff <= 1'b0;
      lfo_sync_ff <= 1'b0;
      lfo_prev_ff <= 1'b0;
      lfo_div_ff <= 5'h00;
    end else begin
      sys_acc_ff <= nxt_sys_acc;
      sys_tick_ff <= sys_wrap;
      if (sys_tick_ff) subc_div_ff <= subc_div_ff + 6'h01;
      lfo_meta_ff <= lfo_clock_pin;
      lfo_sync_ff <= lfo_meta_ff;
      lfo_prev_ff <= lfo_sync_ff;
      if (lfo_rise) lfo_div_ff <= lfo_div_ff + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer 3 countdown
  wire [1:0] mode = t3_ctrl_ff.start_mode_sel;
  wire trim_mode = mode[1];
  wire running = (state_ff == CDT_RUN);
  wire count_tick =
    (t3_ctrl_ff.count_clock_sel == CDT_CLK_SYS) ? sys_tick_ff :
    (t3_ctrl_ff.count_clock_sel == CDT_CLK_SUBC) ? subc_tick :
    (t3_ctrl_ff.count_clock_sel == CDT_CLK_T0) ? chip_events.timer0_underflow :
    chip_events.timer1_underflow;
  // trimming starts on one lfo edge and stops on the next
  wire start_tx = (mode == CDT_START_TX) & chip_events.tx_end;
  wire trim_start = trim_mode & lfo_rise & ~running;
  wire trim_stop = trim_mode & lfo_rise & running;
  wire start_evt = start_tx | trim_start;
  wire rx_stop = t3_ctrl_ff.stop_on_receive & ~trim_mode &
    chip_events.rx_nibble_done & running;
  wire at_zero = (count_ff == 16'h0000);
  // hold-at-zero trimming never underflows, so it raises no flag
  wire underflow = running & count_tick & at_zero & ~start_evt & ~rx_stop & ~trim_stop &
    (mode != CDT_TRIM_HOLD);

  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      CDT_IDLE: begin
        if (start_evt) begin
          nxt_state = CDT_RUN;
          nxt_count = reload_value;
        end
      end
      CDT_RUN: begin
        if (start_evt) begin
          nxt_count = reload_value;
        end else if (rx_stop | trim_stop) begin
          nxt_state = CDT_IDLE;
        end else if (underflow) begin
          if (t3_ctrl_ff.auto_reload_en) begin
            nxt_count = reload_value;
          end else begin
            nxt_state = CDT_IDLE;
          end
        end else if (count_tick & ~at_zero) begin
          nxt_count = count_ff - 16'h0001;
        end
      end
      default: begin
        nxt_state = CDT_IDLE;
        nxt_count = `CDT_RST_COUNT;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= CDT_IDLE;
      count_ff <= `CDT_RST_COUNT;
      t3_uf_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      t3_uf_ff <= underflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake-up timer control; its counter lives next door and reports expiry
  wire wk_expire = wk_run_ff & chip_events.wakeup_expire;
  wire wk_strobe_wr = wr_wk_ctrl & wbyte[`CDT_WK_STROBE_BIT];
  assign nxt_wk_run = wk_strobe_wr ? wbyte[`CDT_WK_RUN_BIT] :
    (wk_expire & ~wk_cfg_ff.wakeup_auto_reload) ? 1'b0 : wk_run_ff;
  // lfo_div_ff runs free, so the first divided tick after a start may come early
  wire wk_div_hit =
    (wk_cfg_ff.wakeup_clock_sel == 2'b00) ? 1'b1 :
    (wk_cfg_ff.wakeup_clock_sel == 2'b01) ? (lfo_div_ff[2:0] == 3'h7) :
    (wk_cfg_ff.wakeup_clock_sel == 2'b10) ? (lfo_div_ff[3:0] == 4'hf) :
    (lfo_div_ff == 5'h1f);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wk_run_ff <= 1'b0;
      wake_req_ff <= 1'b0;
      card_det_ff <= 1'b0;
      trim_req_ff <= 1'b0;
      wk_tick_ff <= 1'b0;
    end else begin
      wk_run_ff <= nxt_wk_run;
      wake_req_ff <= wk_expire & wk_cfg_ff.wakeup_auto_wake;
      card_det_ff <= wk_expire & wk_cfg_ff.wakeup_auto_card_detect;
      trim_req_ff <= wk_expire & wk_cfg_ff.wakeup_auto_trim;
      wk_tick_ff <= wk_run_ff & lfo_rise & wk_div_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: a new event wins over a clear in the same cycle
  wire [1:0] irq_events = {wk_expire, underflow};
  wire [1:0] irq_clear = wr_irq_clear ? wbyte[1:0] : 2'b00;
  assign nxt_status = (irq_status_ff & ~irq_clear) | irq_events;
  // registered so irq is a clean flop output, one cycle behind status
  wire irq_pending = |(irq_status_ff & irq_en_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_ff <= `CDT_RST_IRQ;
      irq_ff <= 1'b0;
    end else begin
      irq_status_ff <= nxt_status;
      irq_ff <= irq_pending;
    end
  end

  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign hrdata = hrdata_ff;
  assign irq = irq_ff;
  assign timer3_underflow = t3_uf_ff;
  assign wake_request = wake_req_ff;
  assign card_detect_start = card_det_ff;
  assign trim_request = trim_req_ff;
  assign wakeup_tick = wk_tick_ff;
  assign wakeup_running = wk_run_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cdt_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_rx_stop_halts: assert property (
    (running && rx_stop && !start_evt) |=> (state_ff == CDT_IDLE))
    else $error("receive stop did not halt the timer");
  a_trim_ignores_rx: assert property (
    (running && trim_mode && chip_events.rx_nibble_done && !lfo_rise && !underflow)
    |=> running)
    else $error("receive stop acted in trimming mode");
  a_tx_start_load: assert property (
    start_tx |=> (running && count_ff == $past(reload_value)))
    else $error("tx end start did not load the reload value");
  a_auto_reload: assert property (
    (underflow && t3_ctrl_ff.auto_reload_en) |=> (running && count_ff == $past(reload_value)))
    else $error("auto reload failed after underflow");
  a_one_shot_stop: assert property (
    (underflow && !t3_ctrl_ff.auto_reload_en)
    |=> (!running && at_zero) ##1 (running || at_zero))
    else $error("one shot timer did not stop at zero");
  a_underflow_flag: assert property (
    underflow |=> (irq_status_ff[`CDT_IRQ_T3_BIT] && t3_uf_ff))
    else $error("underflow flag not set");
  a_sys_tick_rate: assert property (
    sys_tick_ff |=> !sys_tick_ff ##[0:2] sys_tick_ff)
    else $error("13.56 MHz tick spacing wrong");
  a_cascade_dec: assert property (
    (running && t3_ctrl_ff.count_clock_sel == CDT_CLK_T0 && chip_events.timer0_underflow
     && !start_evt && !rx_stop && !trim_stop && !at_zero)
    |=> count_ff == $past(count_ff) - 16'h0001)
    else $error("cascade decrement wrong");
  a_reload_no_disturb: assert property (
    ((wr_reload_hi || wr_reload_lo) && running && !count_tick && !start_evt)
    |=> count_ff == $past(count_ff))
    else $error("reload write disturbed the count");
  a_count_readback: assert property (
    (rd_phase && cdt_hit(haddr, `CDT_IDX_COUNT_LO)) |=> hrdata_ff[7:0] == $past(count_ff[7:0]))
    else $error("counter read back wrong");
  a_wake_request: assert property (
    (wk_expire && wk_cfg_ff.wakeup_auto_wake) |=> wake_request)
    else $error("wake request missing on expiry");
  a_wakeup_strobe: assert property (
    (wr_wk_ctrl && !wbyte[`CDT_WK_STROBE_BIT] && !wk_expire) |=> wk_run_ff == $past(wk_run_ff))
    else $error("running bit changed without strobe");
  a_ctrl_reserved: assert property (
    (t3_ctrl_ff & `CDT_T3_CTRL_RSV_MASK) == 8'h00)
    else $error("reserved control bits set");

  ////////////////////////////////////////////////////////////////////////////
  // counting, read-back, interrupt and wake-up side checks
  a_irq_level: assert property (
    irq_ff == $past(irq_pending))
    else $error("irq level does not follow enabled status");
  a_trim_start_load: assert property (
    trim_start |=> (running && count_ff == $past(reload_value)))
    else $error("trimming edge did not start the timer");
  a_idle_holds: assert property (
    (!running && !start_evt) |=> (count_ff == $past(count_ff)))
    else $error("counter moved while stopped");
  a_tick_decrement: assert property (
    (running && count_tick && !at_zero && !start_evt && !rx_stop && !trim_stop)
    |=> (count_ff == $past(count_ff) - 16'h0001))
    else $error("selected tick did not decrement the counter");
  a_rx_no_stop: assert property (
    (running && !t3_ctrl_ff.stop_on_receive && chip_events.rx_nibble_done
     && !trim_stop && !underflow) |=> running)
    else $error("timer stopped on receive with the stop bit clear");
  a_sys_sel_waits: assert property (
    (running && t3_ctrl_ff.count_clock_sel == CDT_CLK_SYS && !sys_tick_ff
     && !start_evt && !rx_stop && !trim_stop) |=> (count_ff == $past(count_ff)))
    else $error("counter moved between 13.56 MHz ticks");
  a_subc_spacing: assert property (
    subc_tick |=> (!subc_tick) [*8])
    else $error("subcarrier ticks too close together");
  a_read_holds: assert property (
    !rd_phase |=> $stable(hrdata_ff))
    else $error("read data changed outside a read");
  a_wk_tick_div1: assert property (
    (wk_run_ff && lfo_rise && wk_cfg_ff.wakeup_clock_sel == 2'b00) |=> wakeup_tick)
    else $error("undivided wake-up tick missing");
  a_wk_expire_ends: assert property (
    (wk_expire && !wk_cfg_ff.wakeup_auto_reload && !wr_wk_ctrl) |=> !wk_run_ff)
    else $error("wake-up timer kept running after a one-shot expiry");
  a_card_detect: assert property (
    (wk_expire && wk_cfg_ff.wakeup_auto_card_detect) |=> card_detect_start)
    else $error("card detection not launched on expiry");

  // scenarios the bench is expected to reach
  c_auto_reload: cover property (underflow && t3_ctrl_ff.auto_reload_en);
  c_rx_stop: cover property (running && rx_stop);
  c_trim_cycle: cover property (trim_start ##[1:1000] trim_stop);
  c_card_detect: cover property (wk_expire && wk_cfg_ff.wakeup_auto_card_detect);
  c_wake_tick: cover property (wakeup_tick);
endmodule

// *** verification/cdt_timer3_wakeup_tb_top.sv ***
// self-checking bench for the timer 3 / wake-up control block
// assumes rtl/ on the include path; drives the ahb-lite slave and the chip event pulses itself
////////////////////////////////////////////////////////////////////////////////
`include "cdt_params.svh"
module cdt_timer3_wakeup_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cdt_pkg::*;
  localparam cdt_events_t ev_tx = 5'h10;
  localparam cdt_events_t ev_rx = 5'h08;
  localparam cdt_events_t ev_t0 = 5'h04;
  localparam cdt_events_t ev_t1 = 5'h02;
  localparam cdt_events_t ev_wk = 5'h01;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, lfo_clock_pin, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic timer3_underflow, wake_request, card_detect_start, trim_request, wakeup_tick;
  logic wakeup_running;
  cdt_events_t chip_events;
  int n_fail, checked, cycles, uf_seen, n_wake, n_card, n_trim, n_tick;
  cdt_timer3_wakeup i_cdt_timer3_wakeup (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .chip_events(chip_events), .lfo_clock_pin(lfo_clock_pin), .irq(irq),
    .timer3_underflow(timer3_underflow), .wake_request(wake_request),
    .card_detect_start(card_detect_start), .trim_request(trim_request),
    .wakeup_tick(wakeup_tick), .wakeup_running(wakeup_running));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // pulses are one cycle wide, so count them where they stand rather than poll later
  always @(posedge hclk) begin
    cycles++;
    if (timer3_underflow === 1'b1) uf_seen++;
    if (wake_request === 1'b1) n_wake++;
    if (card_detect_start === 1'b1) n_card++;
    if (trim_request === 1'b1) n_trim++;
    if (wakeup_tick === 1'b1) n_tick++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one idle cycle ahead of every transfer hides the read-after-write lag of the slave
  task automatic bus_addr(input logic [7:0] idx, input logic wr);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    bus_addr(idx, 1'b1);
    hwdata <= {24'h0, data};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus_addr(idx, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    check(name, hrdata, {24'h0, exp});
  endtask
  task automatic fire(input cdt_events_t ev, input int n);
    repeat (n) begin
      @(posedge hclk);
      chip_events <= ev;
      @(posedge hclk);
      chip_events <= '0;
    end
  endtask
  task automatic arm(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] ctrl);
    wr(`CDT_IDX_RELOAD_HI, hi);
    wr(`CDT_IDX_RELOAD_LO, lo);
    wr(`CDT_IDX_T3_CTRL, ctrl);
    uf_seen = 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("hreadyout", hreadyout, 1);
    check("hresp", hresp, 0);
    check("irq_rst", irq, 0);
    rd("ctrl_rst", `CDT_IDX_T3_CTRL, 8'h00);
    rd("rl_hi_rst", `CDT_IDX_RELOAD_HI, 8'h00);
    rd("rl_lo_rst", `CDT_IDX_RELOAD_LO, 8'h00);
    rd("cnt_hi_rst", `CDT_IDX_COUNT_HI, 8'h00);
    rd("cnt_lo_rst", `CDT_IDX_COUNT_LO, 8'h00);
    rd("wk_rst", `CDT_IDX_WK_CTRL, 8'h00);
    rd("stat_rst", `CDT_IDX_IRQ_STATUS, 8'h00);
    wr(8'h10, 8'hff);
    rd("unmapped", 8'h10, 8'h00);
    wr(`CDT_IDX_COUNT_LO, 8'h5a);
    rd("cnt_ro", `CDT_IDX_COUNT_LO, 8'h00);
  endtask
  task automatic t_fields();
    wr(`CDT_IDX_T3_CTRL, 8'hff);
    rd("ctrl_rsv", `CDT_IDX_T3_CTRL, 8'hbb);
    wr(`CDT_IDX_WK_CTRL, 8'h80);
    rd("wk_nostrobe", `CDT_IDX_WK_CTRL, 8'h00);
    check("wk_run0", wakeup_running, 0);
    wr(`CDT_IDX_WK_CTRL, 8'hc0);
    rd("wk_strobe", `CDT_IDX_WK_CTRL, 8'h80);
    check("wk_run1", wakeup_running, 1);
    wr(`CDT_IDX_WK_CTRL, 8'h40);
    @(posedge hclk);
    check("wk_stop", wakeup_running, 0);
  endtask
  task automatic t_load();
    arm(8'h01, 8'h02, 8'h12);
    fire(ev_tx, 1);
    rd("load_hi", `CDT_IDX_COUNT_HI, 8'h01);
    rd("load_lo", `CDT_IDX_COUNT_LO, 8'h02);
    wr(`CDT_IDX_RELOAD_LO, 8'h05);
    fire(ev_t0, 1);
    rd("no_disturb", `CDT_IDX_COUNT_LO, 8'h01);
    fire(ev_t1, 1);
    rd("t0_only", `CDT_IDX_COUNT_LO, 8'h01);
    fire(ev_tx, 1);
    rd("new_reload", `CDT_IDX_COUNT_LO, 8'h05);
  endtask
  task automatic t_underflow();
    arm(8'h00, 8'h02, 8'h13);
    wr(`CDT_IDX_IRQ_ENABLE, 8'h01);
    fire(ev_tx, 1);
    fire(ev_t1, 2);
    rd("at_zero", `CDT_IDX_COUNT_LO, 8'h00);
    check("no_uf_yet", uf_seen, 0);
    check("irq_quiet", irq, 0);
    fire(ev_t1, 1);
    repeat (2) @(posedge hclk);
    check("uf_pulse", uf_seen, 1);
    rd("stat_uf", `CDT_IDX_IRQ_STATUS, 8'h01);
    check("irq_on", irq, 1);
    fire(ev_t1, 2);
    rd("stopped", `CDT_IDX_COUNT_LO, 8'h00);
    check("one_uf", uf_seen, 1);
    wr(`CDT_IDX_IRQ_ENABLE, 8'h00);
    repeat (2) @(posedge hclk);
    check("irq_masked", irq, 0);
    wr(`CDT_IDX_IRQ_CLEAR, 8'h01);
    rd("stat_clr", `CDT_IDX_IRQ_STATUS, 8'h00);
  endtask
  task automatic t_restart();
    arm(8'h00, 8'h02, 8'h1b);
    fire(ev_tx, 1);
    fire(ev_t1, 3);
    rd("reloaded", `CDT_IDX_COUNT_LO, 8'h02);
    fire(ev_t1, 1);
    rd("goes_on", `CDT_IDX_COUNT_LO, 8'h01);
    check("uf_restart", uf_seen, 1);
    wr(`CDT_IDX_IRQ_CLEAR, 8'h01);
  endtask
  task automatic t_stop_rx();
    arm(8'h00, 8'h09, 8'h92);
    fire(ev_tx, 1);
    fire(ev_rx, 1);
    fire(ev_t0, 1);
    rd("rx_halt", `CDT_IDX_COUNT_LO, 8'h09);
    wr(`CDT_IDX_T3_CTRL, 8'h12);
    fire(ev_tx, 1);
    fire(ev_rx, 1);
    fire(ev_t0, 1);
    rd("rx_ignored", `CDT_IDX_COUNT_LO, 8'h08);
  endtask
  // lfo edges pass a two-stage synchroniser, so each level is held for several cycles
  task automatic t_trim();
    // the last scenario leaves the count running; halt it so the first edge starts
    wr(`CDT_IDX_T3_CTRL, 8'h92);
    fire(ev_rx, 1);
    arm(8'h00, 8'h09, 8'ha2);
    @(posedge hclk);
    lfo_clock_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    fire(ev_rx, 1);
    fire(ev_t0, 1);
    rd("trim_run", `CDT_IDX_COUNT_LO, 8'h08);
    lfo_clock_pin <= 1'b0;
    repeat (6) @(posedge hclk);
    lfo_clock_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    fire(ev_t0, 1);
    rd("trim_stop", `CDT_IDX_COUNT_LO, 8'h08);
    lfo_clock_pin <= 1'b0;
    wr(`CDT_IDX_T3_CTRL, 8'h02);
    fire(ev_tx, 1);
    fire(ev_t0, 1);
    rd("no_auto", `CDT_IDX_COUNT_LO, 8'h08);
  endtask
  task automatic t_clocks();
    arm(8'h00, 8'h03, 8'h11);
    fire(ev_tx, 1);
    repeat (100) @(posedge hclk);
    check("subc_slow", uf_seen, 0);
    repeat (800) @(posedge hclk);
    check("subc_uf", uf_seen, 1);
    arm(8'h00, 8'h03, 8'h10);
    fire(ev_tx, 1);
    repeat (20) @(posedge hclk);
    check("sys_uf", uf_seen, 1);
    wr(`CDT_IDX_IRQ_CLEAR, 8'h01);
  endtask
  task automatic t_wake();
    wr(`CDT_IDX_WK_CTRL, 8'hf4);
    wr(`CDT_IDX_IRQ_ENABLE, 8'h02);
    check("wk_armed", wakeup_running, 1);
    lfo_clock_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    lfo_clock_pin <= 1'b0;
    check("wk_tick", n_tick, 1);
    fire(ev_wk, 1);
    repeat (2) @(posedge hclk);
    check("wake_req", n_wake, 1);
    check("card_det", n_card, 1);
    check("trim_req", n_trim, 1);
    check("wk_ends", wakeup_running, 0);
    rd("stat_wk", `CDT_IDX_IRQ_STATUS, 8'h02);
    check("irq_wk", irq, 1);
    wr(`CDT_IDX_IRQ_CLEAR, 8'h02);
    repeat (2) @(posedge hclk);
    check("irq_clr", irq, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    chip_events = '0;
    lfo_clock_pin = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_fields();
    t_load();
    t_underflow();
    t_restart();
    t_stop_rx();
    t_trim();
    t_clocks();
    t_wake();
    finish_test();
  end
endmodule
